// ===== core/adc_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host_end #(
    parameter int unsigned DATA_W = adc_link_pkg::DATA_W,
    parameter int unsigned DEPTH  = adc_link_pkg::FIFO_DEPTH
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    adc_link_if.host               link,
    input  wire logic              start_i,
    input  wire logic              power_down_req_i,
    input  wire logic              wake_req_i,
    output logic                   busy_o,
    output logic [DATA_W-1:0]      result_o,
    output logic                   result_valid_o,
    input  wire logic              result_ready_i
);
    typedef enum logic [2:0] {
        IDLE  = 3'b000,
        FRAME = 3'b001,
        QUIET = 3'b010,
        PDOWN = 3'b011,
        WAKE  = 3'b100
    } state_t;
    state_t     st_q;
    logic       cs_n_q, sclk_q, in_m_q, in_s_q, first_q, abort_q;
    logic [1:0] div_q;
    logic [4:0] edge_q;
    logic [4:0] wait_q;
    logic [15:0] sh_q;
    logic       push_q;
    logic [DATA_W-1:0] word_q;
    logic       fifo_ready;
    wire tick     = div_q == 2'(adc_link_pkg::SCLK_DIV - 1);
    wire half     = div_q == 2'(adc_link_pkg::SCLK_DIV / 2 - 1);
    assign link.frame_sel_n = cs_n_q;
    assign link.sclk        = sclk_q;
    assign busy_o           = st_q != IDLE;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            in_m_q <= 1'b0;
            in_s_q <= 1'b0;
        end else begin
            in_m_q <= link.serial_result_out;
            in_s_q <= in_m_q;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= IDLE; cs_n_q <= 1'b1; sclk_q <= 1'b1; div_q <= '0;
            edge_q <= '0; wait_q <= '0; sh_q <= '0; push_q <= 1'b0;
            word_q <= '0; first_q <= 1'b1; abort_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            div_q  <= (st_q == FRAME || st_q == WAKE) ? div_q + 1'b1 : '0;
            unique case (st_q)
                IDLE: begin
                    if (wake_req_i) begin
                        st_q <= WAKE; cs_n_q <= 1'b0; edge_q <= '0;
                    end else if (start_i && fifo_ready) begin
                        st_q <= FRAME; cs_n_q <= 1'b0; edge_q <= '0;
                        abort_q <= power_down_req_i;
                    end
                end
                FRAME, WAKE: begin
                    if (half) begin
                        sclk_q <= 1'b0;
                        edge_q <= edge_q + 1'b1;
                        sh_q   <= {sh_q[14:0], in_s_q};
                    end
                    if (tick) begin
                        sclk_q <= 1'b1;
                    end
                    if (tick && st_q == FRAME && abort_q && edge_q == 5'(adc_link_pkg::EDGE_PD_LO + 1)) begin
                        cs_n_q <= 1'b1; st_q <= PDOWN;
                    end else if (tick && st_q == WAKE && edge_q == 5'(adc_link_pkg::EDGE_WAKE + 1)) begin
                        cs_n_q <= 1'b1; st_q <= QUIET;
                        wait_q <= 5'(adc_link_pkg::RECOVER_CYC);
                    end else if (tick && edge_q == 5'(adc_link_pkg::FRAME_BITS)) begin
                        cs_n_q <= 1'b1; st_q <= QUIET;
                        wait_q <= 5'(adc_link_pkg::QUIET_CYC + 2);
                        push_q <= !first_q;
                        first_q <= 1'b0;
                        // sync delay: each shift holds the bit launched two falls earlier
                        word_q <= sh_q[15-adc_link_pkg::LEAD_ZEROS-1 -: DATA_W];
                    end
                end
                QUIET: begin
                    if (wait_q != '0) begin
                        wait_q <= wait_q - 1'b1;
                    end else begin
                        st_q <= IDLE;
                    end
                end
                PDOWN: begin
                    first_q <= 1'b1;
                    st_q    <= IDLE;
                end
                default: st_q <= IDLE;
            endcase
        end
    end
    result_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .in_data_i  (word_q),
        .in_valid_i (push_q),
        .in_ready_o (fifo_ready),
        .out_data_o (result_o),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i)
    );
endmodule // adc_host_end
`default_nettype wire

// ===== common/adc_link_pkg.sv
// What this block does
// - frame select fall samples and starts conversion
// - frame: four zeros, ten bits MSB first, two zeros
// - first zero at select fall, zeros to edge three
// - MSB appears at fourth falling edge
// - sixteenth falling edge releases the output
// - conversion completes at fourteenth falling edge
// - acquisition starts at rising edge after thirteenth
// - host may release select after sixteen clocks
// - host waits quiet interval before next frame
// - hold select until acquisition, else next invalid
// - select high aborts conversion, output released
// - release between edges two and ten: power-down
// - dummy cycle over ten edges wakes device
// - full power within recovery time after wake
// - host may end dummy after tenth edge
// - dummy may stop short if recovery respected
// - quiet interval at least forty nanoseconds
// - host discards one result after power-up
package adc_link_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned CLK_NS          = 40;
    localparam int unsigned DATA_W          = 10;
    localparam int unsigned FRAME_BITS      = 16;
    localparam int unsigned LEAD_ZEROS      = 4;
    localparam int unsigned EDGE_W          = 5;
    localparam int unsigned EDGE_MSB        = 4;
    localparam int unsigned EDGE_ACQ        = 13;
    localparam int unsigned EDGE_CONV_DONE  = 14;
    localparam int unsigned EDGE_RELEASE    = 16;
    localparam int unsigned EDGE_PD_LO      = 2;
    localparam int unsigned EDGE_PD_HI      = 10;
    localparam int unsigned EDGE_WAKE       = 10;
    localparam int unsigned QUIET_NS        = 40;
    localparam int unsigned RECOVER_NS      = 800;
    localparam int unsigned QUIET_CYC       = (QUIET_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RECOVER_CYC     = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SCLK_DIV        = 4;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam logic [9:0]  RESULT_RESET    = 10'h000;
endpackage

// ===== common/adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
    logic frame_sel_n;
    logic sclk;
    logic serial_result_out;
    logic serial_result_oe;
    modport dev  (input frame_sel_n, input sclk, output serial_result_out, output serial_result_oe);
    modport host (output frame_sel_n, output sclk, input serial_result_out, input serial_result_oe);
endinterface
`default_nettype wire

// ===== core/result_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;
    assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem_q[rd_q];
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // result_fifo
`default_nettype wire

// ===== core/adc_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
module adc_dev_end #(
    parameter int unsigned DATA_W = adc_link_pkg::DATA_W
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    adc_link_if.dev                link,
    input  wire logic [DATA_W-1:0] analog_code_i,
    output logic                   sample_o,
    output logic                   acquiring_o,
    output logic                   conv_done_o,
    output logic                   power_down_o,
    output logic                   full_power_o
);
    logic       cs_m_q, cs_s_q, cs_p_q, ck_m_q, ck_s_q, ck_p_q;
    logic [adc_link_pkg::EDGE_W-1:0] edge_q;
    logic [DATA_W-1:0] shreg_q;
    logic       out_q, oe_q, acq_q, pd_q, waking_q, full_q, valid_q;
    logic [4:0] rec_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
            {ck_m_q, ck_s_q, ck_p_q} <= 3'h0;
        end else begin
            cs_m_q <= link.frame_sel_n;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
            ck_m_q <= link.sclk;
            ck_s_q <= ck_m_q;
            ck_p_q <= ck_s_q;
        end
    end
    wire cs_fall = cs_p_q && !cs_s_q;
    wire cs_rise = !cs_p_q && cs_s_q;
    wire ck_fall = ck_p_q && !ck_s_q && !cs_s_q;
    wire ck_rise = !ck_p_q && ck_s_q && !cs_s_q;
    wire [adc_link_pkg::EDGE_W-1:0] edge_nx = edge_q + 1'b1;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || cs_s_q) begin
            edge_q <= '0;
        end else if (ck_fall && edge_q != 5'h1F) begin
            edge_q <= edge_nx;
        end
    end
    assign link.serial_result_out = out_q;
    assign link.serial_result_oe  = oe_q;
    assign sample_o     = cs_fall && !pd_q;
    assign acquiring_o  = acq_q;
    assign conv_done_o  = ck_fall && edge_nx == 5'(adc_link_pkg::EDGE_CONV_DONE) && !pd_q;
    assign power_down_o = pd_q;
    assign full_power_o = full_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_q    <= 1'b0;
            oe_q     <= 1'b0;
            shreg_q  <= adc_link_pkg::RESULT_RESET;
            acq_q    <= 1'b0;
            pd_q     <= 1'b0;
            waking_q <= 1'b0;
            full_q   <= 1'b0;
            valid_q  <= 1'b0;
            rec_q    <= '0;
        end else begin
            if (cs_fall) begin
                shreg_q <= analog_code_i;
                out_q   <= 1'b0;
                oe_q    <= !pd_q;
                acq_q   <= 1'b0;
                if (pd_q) begin
                    waking_q <= 1'b1;
                end
            end else if (cs_rise) begin
                oe_q <= 1'b0;
                if (edge_q >= 5'(adc_link_pkg::EDGE_PD_LO) && edge_q < 5'(adc_link_pkg::EDGE_PD_HI) && !pd_q) begin
                    pd_q   <= 1'b1;
                    full_q <= 1'b0;
                end
                if (!acq_q) begin
                    valid_q <= 1'b0;
                end
            end else if (ck_fall && !pd_q) begin
                if (edge_nx == 5'(adc_link_pkg::EDGE_RELEASE)) begin
                    oe_q <= 1'b0;
                end
                if (edge_nx >= 5'(adc_link_pkg::EDGE_MSB) && edge_nx < 5'(adc_link_pkg::EDGE_MSB + DATA_W)) begin
                    out_q   <= shreg_q[DATA_W-1] && valid_q;
                    shreg_q <= {shreg_q[DATA_W-2:0], 1'b0};
                end else begin
                    out_q <= 1'b0;
                end
            end else if (ck_fall && waking_q && edge_nx > 5'(adc_link_pkg::EDGE_WAKE)) begin
                pd_q     <= 1'b0;
                waking_q <= 1'b0;
                rec_q    <= 5'(adc_link_pkg::RECOVER_CYC);
            end
            if (ck_rise && edge_q >= 5'(adc_link_pkg::EDGE_ACQ) && !acq_q && !pd_q) begin
                acq_q   <= 1'b1;
                valid_q <= 1'b1;
            end
            if (!pd_q && !full_q) begin
                if (rec_q != '0) begin
                    rec_q <= rec_q - 1'b1;
                end else begin
                    full_q <= 1'b1;
                end
            end
        end
    end
endmodule // adc_dev_end
`default_nettype wire

// ===== verification/adc_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module adc_link_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe
);
    logic       sclk_q;
    logic       pd_q;
    logic [4:0] cnt_q;
    wire        fall_w = sclk_q & ~sclk;
    wire        pd_w   = frame_sel_n & (cnt_q >= 5'h02) & (cnt_q <= 5'h09);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_sys_i) sclk_q <= rst_i | sclk;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || frame_sel_n) cnt_q <= 5'h00;
        else if (fall_w && cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) pd_q <= 1'b0;
        else if (pd_w) pd_q <= 1'b1;
        else if (cnt_q > 5'h0A) pd_q <= 1'b0;
    end
    frame_start_a: assert property ($fell(frame_sel_n) && !pd_q |-> ##[1:6] serial_result_oe)
        else $error("output not driven at frame start");
    lead_zero_a: assert property (serial_result_oe && cnt_q < 5'h04 |-> !serial_result_out)
        else $error("leading bit not zero");
    trail_zero_a: assert property (serial_result_oe && cnt_q == 5'h0F |-> !serial_result_out)
        else $error("trailing bit not zero");
    out_release_a: assert property (cnt_q == 5'h10 |-> ##[0:6] !serial_result_oe)
        else $error("output not released after last edge");
    abort_release_a: assert property (frame_sel_n [*6] |-> !serial_result_oe)
        else $error("output driven while select high");
    sclk_idle_a: assert property (frame_sel_n [*4] |-> sclk)
        else $error("serial clock not idle high");
    sclk_shape_a: assert property ($fell(sclk) |-> ##1 (!sclk || frame_sel_n) ##1 (sclk || frame_sel_n))
        else $error("serial clock low phase wrong");
    quiet_gap_a: assert property ($fell(serial_result_oe) |-> ##1 !$fell(frame_sel_n))
        else $error("frame started inside quiet gap");
    select_hold_a: assert property ($rose(frame_sel_n) |-> cnt_q >= 5'h02)
        else $error("select released too early");
endmodule // adc_link_asserts
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_sys_i, rst_i, start_i, power_down_req_i, wake_req_i, result_ready_i;
    logic        sample_o, acquiring_o, conv_done_o, power_down_o, full_power_o, busy_o, result_valid_o;
    logic        sclk_q, acq_q;
    logic [9:0]  analog_code_i, result_o;
    logic [9:0]  codes [16];
    logic [15:0] frame_bits;
    int          bad_count, checks_done, n_sample, n_done, n_acq, fall_idx;
    adc_link_if link();
    adc_dev_end u_adc_dev_end (.clk_sys_i, .rst_i, .link(link), .analog_code_i, .sample_o, .acquiring_o,
        .conv_done_o, .power_down_o, .full_power_o);
    adc_host_end u_adc_host_end (.clk_sys_i, .rst_i, .link(link), .start_i, .power_down_req_i, .wake_req_i,
        .busy_o, .result_o, .result_valid_o, .result_ready_i);
    adc_link_asserts u_adc_link_asserts (.clk_sys_i, .rst_i, .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
        .serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // capture the wire frame one cycle after each serial clock fall
    always @(posedge clk_sys_i) begin
        sclk_q <= link.sclk;
        acq_q <= acquiring_o;
        n_sample <= n_sample + int'(sample_o);
        n_done <= n_done + int'(conv_done_o);
        n_acq <= n_acq + int'(acquiring_o && !acq_q);
        if (link.frame_sel_n) fall_idx <= 0;
        else if (sclk_q && !link.sclk && fall_idx < 16) begin
            frame_bits[15 - fall_idx] <= link.serial_result_out;
            fall_idx <= fall_idx + 1;
        end
    end
    task automatic final_report;
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 400) begin
            tick(1);
            k++;
        end
        check(16'(busy_o), 16'h0000);
    endtask
    task automatic run_frame(input logic [9:0] code, input logic pd, input logic keep);
        int s0, d0, a0;
        s0 = n_sample;
        d0 = n_done;
        a0 = n_acq;
        analog_code_i = code;
        power_down_req_i = pd;
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
        power_down_req_i = 1'b0;
        tick(1);
        wait_idle();
        tick(4);
        check(16'(n_sample - s0), 16'h0001);
        if (keep) begin
            check(frame_bits, {4'h0, code, 2'b00});
            check(16'(n_done - d0), 16'h0001);
            check(16'(n_acq - a0), 16'h0001);
        end
    endtask
    task automatic pop(input logic [9:0] exp);
        check(16'(result_valid_o), 16'h0001);
        check(16'(result_o), 16'(exp));
        result_ready_i = 1'b1;
        tick(1);
        result_ready_i = 1'b0;
        tick(1);
    endtask
    task automatic t_first;
        run_frame(10'h2AA, 1'b0, 1'b0);
        check(16'(result_valid_o), 16'h0000);
    endtask
    task automatic t_fill;
        for (int i = 0; i < 16; i++) codes[i] = (i == 15) ? 10'h3FF : 10'(i * 10'h0F3);
        for (int i = 0; i < 16; i++) run_frame(codes[i], 1'b0, 1'b1);
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
        tick(1);
        check(16'(busy_o), 16'h0000);
        check(16'(link.frame_sel_n), 16'h0001);
        for (int i = 0; i < 16; i++) pop(codes[i]);
        check(16'(result_valid_o), 16'h0000);
    endtask
    task automatic t_power;
        int k;
        run_frame(10'h0F0, 1'b1, 1'b0);
        check(16'(power_down_o), 16'h0001);
        check(16'(link.serial_result_oe), 16'h0000);
        wake_req_i = 1'b1;
        tick(1);
        wake_req_i = 1'b0;
        tick(1);
        wait_idle();
        check(16'(power_down_o), 16'h0000);
        k = 0;
        while (full_power_o !== 1'b1 && k < adc_link_pkg::RECOVER_CYC + 4) begin
            tick(1);
            k++;
        end
        check(16'(full_power_o), 16'h0001);
        run_frame(10'h123, 1'b0, 1'b0);
        check(16'(result_valid_o), 16'h0000);
        run_frame(10'h321, 1'b0, 1'b1);
        pop(10'h321);
    endtask
    initial begin
        #(40 * 8000);
        bad_count++;
        final_report();
    end
    initial begin
        rst_i = 1'b1;
        start_i = 1'b0;
        power_down_req_i = 1'b0;
        wake_req_i = 1'b0;
        result_ready_i = 1'b0;
        analog_code_i = 10'h000;
        repeat (10) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        tick(1);
        t_first();
        t_fill();
        t_power();
        final_report();
    end
endmodule // testbench
`default_nettype wire
